// [rtl/csh_exec.sv]
// execution unit for conditional skips, halt and reverse subtract
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module csh_exec #(
  parameter int DATA_W = csh_pkg::CSH_DATA_W,
  parameter int PC_W   = csh_pkg::CSH_PC_W
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire csh_pkg::csh_instr_t instr,
  output logic                     instr_ready,
  input  wire logic [PC_W-1:0]     pc,
  input  wire logic [2:0]          next_len,
  output logic                     pc_load,
  output logic [PC_W-1:0]          pc_value,
  output logic                     skipping,
  input  wire logic [DATA_W-1:0]   reg_first,
  input  wire logic [DATA_W-1:0]   reg_second,
  output logic                     reg_we,
  output logic [DATA_W-1:0]        reg_wdata,
  output csh_pkg::csh_flags_t      flags,
  output logic                     core_halted,
  output logic                     conv_standby,
  output logic                     mem_standby,
  input  wire logic                wake_watchdog,
  input  wire logic                wake_switch,
  input  wire logic                wake_result
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSH_ST_IDLE   = 2'b00,
    CSH_ST_SKIP   = 2'b01,
    CSH_ST_HALTED = 2'b10
  } csh_state_t;

  csh_state_t          state;
  csh_state_t          next_state;
  logic [1:0]          remain;
  logic [1:0]          next_remain;
  logic [PC_W-1:0]     skip_pc;
  logic [PC_W-1:0]     next_skip_pc;
  logic                next_pc_load;
  logic [PC_W-1:0]     next_pc_value;
  logic                next_reg_we;
  logic [DATA_W-1:0]   next_reg_wdata;
  csh_pkg::csh_flags_t next_flags;
  logic [DATA_W-1:0]   sub_result;
  csh_pkg::csh_flags_t sub_flags;
  logic                cond;
  logic                wake;

  csh_rsub #(
    .W (DATA_W)
  ) u_rsub (
    .first  (reg_first),
    .second (instr.use_const ? instr.konst : reg_second),
    .result (sub_result),
    .flags  (sub_flags)
  );

  assign wake         = wake_watchdog | wake_switch | wake_result;
  assign core_halted  = (state == CSH_ST_HALTED);
  assign conv_standby = core_halted;
  assign mem_standby  = core_halted;
  assign skipping     = (state == CSH_ST_SKIP);
  assign instr_ready  = (state == CSH_ST_IDLE);

  // ---------------------------------------------------------------
  // condition selection
  // ---------------------------------------------------------------
  always_comb begin
    case (instr.op)
      csh_pkg::CSH_OP_SKIP_NEG:   cond = flags.sign;
      csh_pkg::CSH_OP_SKIP_NOOVF: cond = !flags.ovf;
      csh_pkg::CSH_OP_SKIP_OVF:   cond = flags.ovf;
      csh_pkg::CSH_OP_SKIP_POS:   cond = !flags.sign;
      default:                    cond = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_remain    = remain;
    next_skip_pc   = skip_pc;
    next_pc_load   = 1'b0;
    next_pc_value  = pc_value;
    next_reg_we    = 1'b0;
    next_reg_wdata = reg_wdata;
    next_flags     = flags;
    case (state)
      CSH_ST_IDLE: begin
        if (instr.valid) begin
          case (instr.op)
            csh_pkg::CSH_OP_SKIP_NEG,
            csh_pkg::CSH_OP_SKIP_NOOVF,
            csh_pkg::CSH_OP_SKIP_OVF,
            csh_pkg::CSH_OP_SKIP_POS: begin
              // flags are left alone either way
              if (cond && instr.skip_n >= csh_pkg::CSH_SKIP_MIN) begin
                next_state   = CSH_ST_SKIP;
                next_remain  = instr.skip_n;
                next_skip_pc = pc + PC_W'(csh_pkg::CSH_SKIP_BYTES);
              end
            end
            csh_pkg::CSH_OP_HALT: begin
              next_state = CSH_ST_HALTED;
            end
            csh_pkg::CSH_OP_RSUB: begin
              next_reg_we    = 1'b1;
              next_reg_wdata = sub_result;
              next_flags     = sub_flags;
            end
            default: begin
            end
          endcase
        end
      end
      CSH_ST_SKIP: begin
        // one cycle per skipped instruction, adding its byte length
        next_skip_pc = skip_pc + PC_W'(next_len);
        next_remain  = remain - 2'h1;
        if (remain == 2'h1) begin
          next_state    = CSH_ST_IDLE;
          next_pc_load  = 1'b1;
          next_pc_value = skip_pc + PC_W'(next_len);
        end
      end
      CSH_ST_HALTED: begin
        if (wake) begin
          next_state = CSH_ST_IDLE;
        end
      end
      default: next_state = CSH_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= CSH_ST_IDLE;
      remain    <= 2'h0;
      skip_pc   <= '0;
      pc_load   <= 1'b0;
      pc_value  <= '0;
      reg_we    <= 1'b0;
      reg_wdata <= '0;
      flags     <= '0;
    end else begin
      state     <= next_state;
      remain    <= next_remain;
      skip_pc   <= next_skip_pc;
      pc_load   <= next_pc_load;
      pc_value  <= next_pc_value;
      reg_we    <= next_reg_we;
      reg_wdata <= next_reg_wdata;
      flags     <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_neg_skip;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_SKIP_NEG
     && flags.sign && instr.skip_n == 2'h1) |=> skipping ##1 pc_load;
  endproperty
  a_neg_skip: assert property (p_neg_skip)
    else $error("negative skip did not load pc");

  property p_noovf_skip;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_SKIP_NOOVF
     && !flags.ovf && instr.skip_n != 2'h0) |=> skipping;
  endproperty
  a_noovf_skip: assert property (p_noovf_skip)
    else $error("no-overflow skip not taken");

  property p_ovf_noskip;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_SKIP_OVF
     && !flags.ovf) |=> !skipping;
  endproperty
  a_ovf_noskip: assert property (p_ovf_noskip)
    else $error("overflow skip taken with overflow clear");

  property p_pos_noskip;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_SKIP_POS
     && flags.sign) |=> !skipping;
  endproperty
  a_pos_noskip: assert property (p_pos_noskip)
    else $error("positive skip taken with sign set");

  property p_skip3_len;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_SKIP_NEG
     && flags.sign && instr.skip_n == 2'h3) |=> skipping [*3] ##1 pc_load;
  endproperty
  a_skip3_len: assert property (p_skip3_len)
    else $error("three-instruction skip took wrong cycle count");

  property p_halt;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_HALT)
      |=> core_halted && conv_standby && mem_standby;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not stop core");

  property p_wake;
    @(posedge clk) disable iff (srst)
    core_halted && !wake |=> core_halted;
  endproperty
  a_wake: assert property (p_wake)
    else $error("core resumed without wake event");

  property p_rsub;
    @(posedge clk) disable iff (srst)
    (instr_ready && instr.valid && instr.op == csh_pkg::CSH_OP_RSUB
     && !instr.use_const)
      |=> reg_we && reg_wdata == DATA_W'($past(reg_second) - $past(reg_first));
  endproperty
  a_rsub: assert property (p_rsub)
    else $error("reverse subtract result wrong");

  property p_flags_kept;
    @(posedge clk) disable iff (srst)
    (skipping ||
     (instr_ready && instr.valid && instr.op != csh_pkg::CSH_OP_RSUB))
      |=> $stable(flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags changed outside subtract");

  c_skip:  cover property (@(posedge clk) disable iff (srst) pc_load);
  c_halt:  cover property (@(posedge clk) disable iff (srst)
                           core_halted ##1 !core_halted);
  c_rsub:  cover property (@(posedge clk) disable iff (srst) reg_we);

endmodule
`default_nettype wire

// [shared/csh_pkg.sv]
// package: opcodes, flag layout and constants for the skip/halt/subtract unit
package csh_pkg;

  // ---------------------------------------------------------------
  // opcode classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CSH_OP_NONE       = 3'b000,
    CSH_OP_SKIP_NEG   = 3'b001,
    CSH_OP_SKIP_NOOVF = 3'b010,
    CSH_OP_SKIP_OVF   = 3'b011,
    CSH_OP_SKIP_POS   = 3'b100,
    CSH_OP_HALT       = 3'b101,
    CSH_OP_RSUB       = 3'b110
  } csh_op_t;

  // ---------------------------------------------------------------
  // sizes and counts
  // ---------------------------------------------------------------
  localparam int          CSH_DATA_W      = 24;
  localparam int          CSH_PC_W        = 16;
  localparam logic [1:0]  CSH_SKIP_MIN    = 2'h1;
  localparam logic [1:0]  CSH_SKIP_MAX    = 2'h3;
  localparam logic [2:0]  CSH_LEN_MIN     = 3'h1;
  localparam logic [2:0]  CSH_SKIP_BYTES  = 3'h1;
  localparam logic [2:0]  CSH_HALT_BYTES  = 3'h1;

  // flag positions in the packed flag word
  localparam int CSH_FLAG_ZERO  = 0;
  localparam int CSH_FLAG_SIGN  = 1;
  localparam int CSH_FLAG_OVF   = 2;
  localparam int CSH_FLAG_CARRY = 3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic carry;
    logic ovf;
    logic sign;
    logic zero;
  } csh_flags_t;

  typedef struct packed {
    logic                  valid;
    csh_op_t               op;
    logic [1:0]            skip_n;
    logic                  use_const;
    logic [CSH_DATA_W-1:0] konst;
  } csh_instr_t;

endpackage

// [rtl/csh_rsub.sv]
// reverse subtract datapath: result = second - first, with flag outputs
`timescale 1ns/1ps
`default_nettype none

module csh_rsub #(
  parameter int W = 24
) (
  input  wire logic [W-1:0]       first,
  input  wire logic [W-1:0]       second,
  output logic [W-1:0]            result,
  output csh_pkg::csh_flags_t     flags
);

  logic [W:0] diff;

  always_comb begin
    diff         = {1'b0, second} - {1'b0, first};
    result       = diff[W-1:0];
    // carry means borrow out of the top bit
    flags.carry  = diff[W];
    flags.ovf    = (second[W-1] != first[W-1]) && (diff[W-1] != second[W-1]);
    flags.sign   = diff[W-1];
    flags.zero   = (diff[W-1:0] == '0);
  end

endmodule
`default_nettype wire

// [dv/csh_tb.sv]
// self-checking testbench for the skip, halt and reverse subtract executor
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module testbench;
  logic                clk, srst, instr_ready, pc_load, skipping, reg_we;
  logic                core_halted, conv_standby, mem_standby;
  csh_pkg::csh_instr_t instr;
  csh_pkg::csh_flags_t flags, exp_f;
  logic [15:0]         pc, pc_value;
  logic [2:0]          next_len, wake;
  logic [23:0]         reg_first, reg_second, reg_wdata;
  int                  n_mismatch, compares, cycles;

  csh_exec i_dut (
    .clk(clk), .srst(srst), .instr(instr), .instr_ready(instr_ready),
    .pc(pc), .next_len(next_len), .pc_load(pc_load),
    .pc_value(pc_value), .skipping(skipping), .reg_first(reg_first),
    .reg_second(reg_second), .reg_we(reg_we), .reg_wdata(reg_wdata),
    .flags(flags), .core_halted(core_halted),
    .conv_standby(conv_standby), .mem_standby(mem_standby),
    .wake_watchdog(wake[0]), .wake_switch(wake[1]),
    .wake_result(wake[2])
  );

  // ---------------------------------------------------------------
  // clock, timeout and closing report
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // the whole run needs well under 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // drivers and scenarios
  // ---------------------------------------------------------------
  task automatic issue(csh_pkg::csh_op_t op, logic [1:0] n, logic uc,
                       logic [23:0] k);
    instr = '{1'b1, op, n, uc, k};
    @(negedge clk);
    instr.valid = 1'b0;
  endtask

  // whichever operand source is unused holds a decoy value
  task automatic t_rsub(logic [23:0] a, logic [23:0] b, logic uc);
    logic [24:0] d;
    @(negedge clk);
    d = {1'b0, b} - {1'b0, a};
    exp_f = '{d[24], (a[23] != b[23]) && (d[23] != b[23]), d[23],
              d[23:0] == 24'h0};
    reg_first = a;
    reg_second = uc ? ~b : b;
    issue(csh_pkg::CSH_OP_RSUB, 2'h1, uc, uc ? b : ~b);
    `CHK("reg_we", 1'b1, reg_we)
    `CHK("reg_wdata", d[23:0], reg_wdata)
    `CHK("flags", exp_f, flags)
    @(negedge clk);
    `CHK("reg_we", 1'b0, reg_we)
    $display("test rsub %h %h done", a, b);
  endtask

  task automatic t_skip(csh_pkg::csh_op_t op, logic [1:0] n, logic take);
    logic [15:0] exp_pc;
    @(negedge clk);
    exp_pc = 16'h0011;
    issue(op, n, 1'b0, 24'h0);
    if (take) begin
      for (int i = 0; i < n; i++) begin
        `CHK("skipping", 1'b1, skipping)
        `CHK("instr_ready", 1'b0, instr_ready)
        next_len = 3'(i + 2);
        exp_pc += 16'(i + 2);
        @(negedge clk);
      end
    end
    `CHK("skipping", 1'b0, skipping)
    `CHK("pc_load", take, pc_load)
    if (take)
      `CHK("pc_value", exp_pc, pc_value)
    `CHK("flags", exp_f, flags)
    $display("test skip op %0d n %0d done", op, n);
  endtask

  task automatic t_halt();
    for (int w = 0; w < 3; w++) begin
      @(negedge clk);
      issue(csh_pkg::CSH_OP_HALT, 2'h1, 1'b0, 24'h0);
      `CHK("core_halted", 1'b1, core_halted)
      `CHK("conv_standby", 1'b1, conv_standby)
      `CHK("mem_standby", 1'b1, mem_standby)
      @(negedge clk);
      instr.op = csh_pkg::CSH_OP_RSUB;
      instr.valid = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("reg_we", 1'b0, reg_we)
      `CHK("core_halted", 1'b1, core_halted)
      instr.valid = 1'b0;
      wake = 3'(1 << w);
      @(negedge clk);
      `CHK("core_halted", 1'b0, core_halted)
      `CHK("mem_standby", 1'b0, mem_standby)
      `CHK("flags", exp_f, flags)
      wake = 3'h0;
    end
    $display("test halt done");
  endtask

  initial begin
    srst = 1'b1;
    instr = '0;
    pc = 16'h0010;
    next_len = 3'h1;
    reg_first = 24'h0;
    reg_second = 24'h0;
    wake = 3'h0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    `CHK("instr_ready", 1'b1, instr_ready)
    `CHK("flags", 4'h0, flags)
    $display("test reset done");
    t_rsub(24'h000005, 24'h000003, 1'b0);
    t_skip(csh_pkg::CSH_OP_SKIP_NEG, 2'h3, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_NEG, 2'h1, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_POS, 2'h1, 1'b0);
    t_skip(csh_pkg::CSH_OP_SKIP_NOOVF, 2'h2, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_OVF, 2'h1, 1'b0);
    t_rsub(24'h000001, 24'h800000, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_OVF, 2'h2, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_NOOVF, 2'h3, 1'b0);
    t_skip(csh_pkg::CSH_OP_SKIP_POS, 2'h1, 1'b1);
    t_skip(csh_pkg::CSH_OP_SKIP_NEG, 2'h2, 1'b0);
    t_rsub(24'h000007, 24'h000007, 1'b0);
    t_skip(csh_pkg::CSH_OP_SKIP_POS, 2'h0, 1'b0);
    t_halt();
    end_of_test();
  end
endmodule

`default_nettype wire
